/* File: design/adc_pipe_pkg.sv */
// Shared constants and carrier types for the pipelined converter output logic
package adc_pipe_pkg;

  // Word and stage geometry
  localparam int CODE_W       = 12;
  localparam int STAGE_W      = 4;
  localparam int NUM_STAGES   = 4;
  localparam int NUM_RESIDUE  = 3;

  // Partial result weights: a gain of 8 per stage, so each stage shifts by three bits
  localparam int STAGE_SHIFT  = 3;
  localparam int SUM_W        = 14;

  // Removes the one-bit redundancy bias of the three residue stages
  localparam logic [SUM_W-1:0] CORR_OFFSET = 14'h0248;
  localparam logic [SUM_W-1:0] CODE_MAX    = 14'h0fff;

  // Offset-binary reference codes
  localparam logic [CODE_W-1:0] CODE_ALL_ONES  = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ALL_ZEROS = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MID_UP    = 12'h800;
  localparam logic [CODE_W-1:0] CODE_MID_DOWN  = 12'h7ff;

  // Master clock cycles from sample to presented code
  localparam int LATENCY_CYC   = 3;
  localparam int FILL_W        = 2;
  localparam logic [FILL_W-1:0] FILL_DONE = 2'h3;

  // One master clock cycle spans two system clocks, one per phase
  localparam int SYS_CLK_NS    = 10;
  localparam int CONV_DIV      = 2;
  localparam int PHASE_CYC     = CONV_DIV / 2;

  // Source-side clock figures, kept for reference by the receiving logic
  localparam int CLK_PULSE_MIN_NS = 90;
  localparam int CLK_PULSE_MAX_NS = 110;
  localparam int DUTY_PCT         = 50;

  // Buffer between correction and output latch
  localparam int FIFO_DEPTH    = 4;

  typedef struct packed {
    logic [STAGE_W-1:0] r3;
    logic [STAGE_W-1:0] r2;
    logic [STAGE_W-1:0] r1;
    logic [STAGE_W-1:0] r0;
  } stage_set_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              over;
    logic              under;
  } code_word_t;

  localparam int WORD_W = CODE_W + 2;

  typedef enum logic [1:0] {
    PH_SAMPLE = 2'b01,
    PH_HOLD   = 2'b10
  } phase_t;

endpackage

/* File: design/stage_delay.sv */
// Enabled shift register that delays one stage's partial result
`timescale 1ns/10ps
module stage_delay #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             shift_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] data_o
);

  logic [WIDTH-1:0] taps [DEPTH];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        taps[i] <= '0;
      end
    end else if (shift_i) begin
      taps[0] <= data_i;
      for (int i = 1; i < DEPTH; i++) begin
        taps[i] <= taps[i-1];
      end
    end
  end

  assign data_o = taps[DEPTH-1];

endmodule

/* File: design/word_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Keep the unused-after-reset memory defined for simulation readability
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = '0;
    end
  end

endmodule

/* File: design/adc_pipe_output.sv */
// Digital output logic of a 12-bit pipelined converter: phases, alignment, correction, latch
`timescale 1ns/10ps

module adc_pipe_output (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire adc_pipe_pkg::stage_set_t  stage_result_i,
  output logic                           sample_phase_o,
  output logic                           hold_phase_o,
  output logic [adc_pipe_pkg::NUM_STAGES-1:0] stage_sample_o,
  output logic [adc_pipe_pkg::CODE_W-1:0] code_o,
  output logic                           code_msb_output_o,
  output logic                           code_lsb_output_o,
  output logic                           code_valid_o,
  output logic                           over_range_o,
  output logic                           under_range_o,
  output logic                           overrun_o
);

  adc_pipe_pkg::phase_t              phase;
  adc_pipe_pkg::phase_t              next_phase;
  logic                              half_tick;
  logic                              conv_tick;
  logic [adc_pipe_pkg::STAGE_W-1:0]  stage_raw [adc_pipe_pkg::NUM_STAGES];
  logic [adc_pipe_pkg::STAGE_W-1:0]  stage_cap [adc_pipe_pkg::NUM_STAGES];
  logic [adc_pipe_pkg::STAGE_W-1:0]  stage_aln [adc_pipe_pkg::NUM_STAGES];
  logic [adc_pipe_pkg::SUM_W-1:0]    raw_sum;
  adc_pipe_pkg::code_word_t          corr_word;
  adc_pipe_pkg::code_word_t          next_corr;
  logic                              corr_valid;
  logic                              fifo_in_ready;
  logic                              fifo_out_valid;
  logic [adc_pipe_pkg::WORD_W-1:0]   fifo_out_data;
  adc_pipe_pkg::code_word_t          fifo_word;
  logic                              latch_load;
  logic [adc_pipe_pkg::FILL_W-1:0]   fill_count;

  // Partial result weighting with overlap; the redundant bit of each stage after stage 0
  // lands on the lsb of the stage above, so an off-by-one decision self-corrects
  function automatic logic [adc_pipe_pkg::SUM_W-1:0] weigh(
    input logic [adc_pipe_pkg::STAGE_W-1:0] part,
    input int                               pos
  );
    logic [adc_pipe_pkg::SUM_W-1:0] wide;
    wide = adc_pipe_pkg::SUM_W'(part);
    weigh = wide << (adc_pipe_pkg::STAGE_SHIFT * pos);
  endfunction

  // Clamp to the twelve-bit range and mark saturation
  function automatic adc_pipe_pkg::code_word_t clamp(
    input logic [adc_pipe_pkg::SUM_W-1:0] sum
  );
    adc_pipe_pkg::code_word_t w;
    w.over  = 1'b0;
    w.under = 1'b0;
    w.code  = sum[adc_pipe_pkg::CODE_W-1:0];
    if (sum < adc_pipe_pkg::CORR_OFFSET) begin
      w.code  = adc_pipe_pkg::CODE_ALL_ZEROS;
      w.under = 1'b1;
    end else if ((sum - adc_pipe_pkg::CORR_OFFSET) > adc_pipe_pkg::CODE_MAX) begin
      w.code  = adc_pipe_pkg::CODE_ALL_ONES;
      w.over  = 1'b1;
    end else begin
      w.code  = adc_pipe_pkg::CODE_W'(sum - adc_pipe_pkg::CORR_OFFSET);
    end
    clamp = w;
  endfunction

  // Phase generator: each system clock is one half of the master cycle.
  // One-hot codes can never show both phases at once, which keeps them non-overlapping.
  always_comb begin
    case (phase)
      adc_pipe_pkg::PH_SAMPLE: next_phase = adc_pipe_pkg::PH_HOLD;
      adc_pipe_pkg::PH_HOLD:   next_phase = adc_pipe_pkg::PH_SAMPLE;
      default:                 next_phase = adc_pipe_pkg::PH_SAMPLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= adc_pipe_pkg::PH_SAMPLE;
    end else begin
      phase <= next_phase;
    end
  end

  assign half_tick      = !rst_i;
  assign conv_tick      = !rst_i && (phase == adc_pipe_pkg::PH_HOLD);
  assign sample_phase_o = !rst_i && (phase == adc_pipe_pkg::PH_SAMPLE);
  assign hold_phase_o   = !rst_i && (phase == adc_pipe_pkg::PH_HOLD);

  assign stage_raw[0] = stage_result_i.r0;
  assign stage_raw[1] = stage_result_i.r1;
  assign stage_raw[2] = stage_result_i.r2;
  assign stage_raw[3] = stage_result_i.r3;

  genvar k;
  generate
    for (k = 0; k < adc_pipe_pkg::NUM_STAGES; k++) begin : g_stage
      // Even stages sample with the front end, odd stages on the inverse phase
      if ((k % 2) == 0) begin : g_even
        assign stage_sample_o[k] = sample_phase_o;
      end else begin : g_odd
        assign stage_sample_o[k] = hold_phase_o;
      end

      // A stage's result is settled at the end of its own amplify phase
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stage_cap[k] <= '0;
        end else if (!stage_sample_o[k]) begin
          stage_cap[k] <= stage_raw[k];
        end
      end

      // Earlier stages wait longer; the last flash stage needs no delay
      if (k < adc_pipe_pkg::NUM_RESIDUE) begin : g_delay
        stage_delay #(
          .WIDTH (adc_pipe_pkg::STAGE_W),
          .DEPTH (adc_pipe_pkg::NUM_RESIDUE - k)
        ) u_delay (
          .clk_i   (clk_i),
          .rst_i   (rst_i),
          .shift_i (half_tick),
          .data_i  (stage_cap[k]),
          .data_o  (stage_aln[k])
        );
      end else begin : g_direct
        assign stage_aln[k] = stage_cap[k];
      end
    end
  endgenerate

  // Overlapping sum of the aligned parts, stage 0 carries the most weight
  assign raw_sum = weigh(stage_aln[0], 3) + weigh(stage_aln[1], 2)
                 + weigh(stage_aln[2], 1) + weigh(stage_aln[3], 0);

  always_comb begin
    next_corr = clamp(raw_sum);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      corr_word  <= '0;
      corr_valid <= 1'b0;
    end else begin
      corr_valid <= conv_tick;
      if (conv_tick) begin
        corr_word <= next_corr;
      end
    end
  end

  // The buffer drains only on the master cycle tick, so a burst of up to FIFO_DEPTH words from the
  // correction side backs up here; further words are dropped and set overrun_o
  word_fifo #(
    .WIDTH (adc_pipe_pkg::WORD_W),
    .DEPTH (adc_pipe_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (corr_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (corr_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (conv_tick),
    .out_data_o  (fifo_out_data)
  );

  assign fifo_word  = adc_pipe_pkg::code_word_t'(fifo_out_data);
  assign latch_load = conv_tick && fifo_out_valid;

  // A word refused by a full buffer is dropped and flagged until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_o <= 1'b0;
    end else if (corr_valid && !fifo_in_ready) begin
      overrun_o <= 1'b1;
    end
  end

  // Output latch, updated once per master cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_o        <= adc_pipe_pkg::CODE_ALL_ZEROS;
      over_range_o  <= 1'b0;
      under_range_o <= 1'b0;
    end else if (latch_load) begin
      code_o        <= fifo_word.code;
      over_range_o  <= fifo_word.over;
      under_range_o <= fifo_word.under;
    end
  end

  assign code_msb_output_o = code_o[adc_pipe_pkg::CODE_W-1];
  assign code_lsb_output_o = code_o[0];

  // Codes latched before the pipeline has filled carry no real sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fill_count   <= '0;
      code_valid_o <= 1'b0;
    end else if (latch_load) begin
      if (fill_count != adc_pipe_pkg::FILL_DONE) begin
        fill_count <= fill_count + 1'b1;
      end
      code_valid_o <= (fill_count == adc_pipe_pkg::FILL_DONE);
    end
  end

endmodule

/* File: test/adc_pipe_output_assertions.sv */
// Concurrent checks on the ports of the converter output logic
`timescale 1ns/10ps
module adc_pipe_output_checker (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sample_phase_o,
  input  wire logic        hold_phase_o,
  input  wire logic [3:0]  stage_sample_o,
  input  wire logic [11:0] code_o,
  input  wire logic        code_msb_output_o,
  input  wire logic        code_lsb_output_o,
  input  wire logic        code_valid_o,
  input  wire logic        over_range_o,
  input  wire logic        under_range_o,
  input  wire logic        overrun_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hold_sample;
    hold_phase_o ##1 sample_phase_o;
  endsequence

  a_phase_excl: assert property (!(sample_phase_o && hold_phase_o))
    else $error("phases overlap");
  a_phase_order: assert property (sample_phase_o |=> s_hold_sample)
    else $error("phase order broken");
  a_stage_invert: assert property (
    stage_sample_o == {hold_phase_o, sample_phase_o, hold_phase_o, sample_phase_o})
    else $error("stage phases not alternating");
  a_code_stands: assert property ($changed(code_o) |=> $stable(code_o))
    else $error("code changed twice in one master cycle");
  a_msb_bit: assert property (code_msb_output_o == code_o[11])
    else $error("msb output wrong");
  a_lsb_bit: assert property (code_lsb_output_o == code_o[0])
    else $error("lsb output wrong");
  a_over_full: assert property (over_range_o |-> code_o == 12'hfff && !under_range_o)
    else $error("over range without full scale");
  a_under_zero: assert property (under_range_o |-> code_o == 12'h000)
    else $error("under range without zero code");
  a_fill_wait: assert property ($fell(rst_i) |-> !code_valid_o [*6])
    else $error("valid before pipeline filled");
  a_valid_keep: assert property (code_valid_o |=> code_valid_o)
    else $error("valid dropped in stream");
  a_overrun_keep: assert property (overrun_o |=> overrun_o)
    else $error("overrun flag lost");
  c_full_scale: cover property (code_valid_o && over_range_o);
endmodule

bind adc_pipe_output adc_pipe_output_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .sample_phase_o(sample_phase_o),
  .hold_phase_o(hold_phase_o), .stage_sample_o(stage_sample_o), .code_o(code_o),
  .code_msb_output_o(code_msb_output_o), .code_lsb_output_o(code_lsb_output_o),
  .code_valid_o(code_valid_o), .over_range_o(over_range_o),
  .under_range_o(under_range_o), .overrun_o(overrun_o)
);

/* File: test/code_receiver.sv */
// Receiving logic model that captures presented codes
`timescale 1ns/10ps
module code_receiver (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        valid_i,
  input  wire logic [11:0] code_i,
  output logic      [11:0] last_o,
  output logic      [15:0] count_o
);
  // Words presented before the pipeline has filled are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_o  <= 12'h000;
      count_o <= 16'h0000;
    end else if (valid_i) begin
      last_o  <= code_i;
      count_o <= count_o + 16'h0001;
    end
  end
endmodule

/* File: test/adc_pipe_output_tb_top.sv */
// Self-checking bench for the converter output logic
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module adc_pipe_output_tb_top;
  localparam int LAT = adc_pipe_pkg::LATENCY_CYC;
  logic                     clk_i;
  logic                     rst_i;
  adc_pipe_pkg::stage_set_t stage_result;
  logic                     sample_ph, hold_ph, msb, lsb, valid, over, under, overrun;
  logic [3:0]               stage_smp;
  logic [11:0]              code, rx_last;
  logic [15:0]              rx_count;
  int                       miscompares, checked;
  logic [15:0]              sets [6] = '{16'h0115, 16'h7015, 16'h7019, 16'h0111,
                                         16'hffff, 16'h0000};

  adc_pipe_output dut_u (.clk_i(clk_i), .rst_i(rst_i), .stage_result_i(stage_result),
    .sample_phase_o(sample_ph), .hold_phase_o(hold_ph), .stage_sample_o(stage_smp),
    .code_o(code), .code_msb_output_o(msb), .code_lsb_output_o(lsb), .code_valid_o(valid),
    .over_range_o(over), .under_range_o(under), .overrun_o(overrun));
  code_receiver rx_u (.clk_i(clk_i), .rst_i(rst_i), .valid_i(valid), .code_i(code),
    .last_o(rx_last), .count_o(rx_count));

  // Even duty system clock, well above the minimum rate
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic adc_pipe_pkg::code_word_t expect_word(logic [15:0] s);
    int r;
    r = int'(s[3:0])*512 + int'(s[7:4])*64 + int'(s[11:8])*8 + int'(s[15:12]) - 32'sh248;
    if (r > 32'sh0fff) return '{12'hfff, 1'b1, 1'b0};
    if (r < 32'sh0) return '{12'h000, 1'b0, 1'b1};
    return '{r[11:0], 1'b0, 1'b0};
  endfunction

  task automatic stop_test();
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_reset();
    @(posedge clk_i) #1;
    `CHK("reset_state", 22'h0, {sample_ph, hold_ph, stage_smp, code, valid, over, under, overrun})
  endtask

  // Valid may only rise once three codes have passed through
  task automatic start_up();
    int n;
    @(posedge clk_i) rst_i <= 1'b0;
    #1;
    `CHK("first_phase", 1'b1, sample_ph)
    n = 0;
    while (valid !== 1'b1 && n < 20) begin
      @(posedge clk_i) #1;
      n++;
    end
    `CHK("fill_time", 1'b1, n >= 2*LAT && n <= 2*LAT+4)
  endtask

  task automatic phases();
    logic prev;
    prev = sample_ph;
    repeat (6) begin
      @(posedge clk_i) #1;
      `CHK("phase_excl", 1'b1, sample_ph ^ hold_ph)
      `CHK("phase_swap", ~prev, sample_ph)
      `CHK("stage_phase", {hold_ph, sample_ph, hold_ph, sample_ph}, stage_smp)
      prev = sample_ph;
    end
  endtask

  task automatic code_case(logic [15:0] s);
    adc_pipe_pkg::code_word_t w;
    w = expect_word(s);
    @(posedge clk_i) stage_result <= s;
    repeat (8) @(posedge clk_i);
    #1;
    `CHK("word", w, {code, over, under})
    `CHK("pins", {w.code[11], w.code[0]}, {msb, lsb})
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("stands", w.code, code)
    `CHK("receiver", w.code, rx_last)
  endtask

  // A changed sample must reach the bus after the documented latency
  task automatic latency_step();
    int n;
    @(posedge clk_i) stage_result <= 16'h0115;
    n = 0;
    while (code !== 12'h800 && n < 16) begin
      @(posedge clk_i) #1;
      n++;
    end
    `CHK("latency", 1'b1, n >= 2*LAT-2 && n <= 2*LAT+3)
  endtask

  task automatic reset_mid();
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("mid_reset", 13'h0, {code, valid})
    @(posedge clk_i) rst_i <= 1'b0;
    repeat (14) @(posedge clk_i);
    #1;
    `CHK("refill", 13'h1001, {code, valid})
  endtask

  initial begin
    rst_i = 1'b1;
    stage_result = '0;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge clk_i);
    check_reset();
    start_up();
    phases();
    for (int i = 0; i < 6; i++) code_case(sets[i]);
    latency_step();
    reset_mid();
    `CHK("no_overrun", 1'b0, overrun)
    `CHK("rx_active", 1'b1, rx_count != 16'h0000)
    stop_test();
  end

  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
endmodule
